// File: pad_model.sv
// Pad model: resolves each pin of ports A, B and C from router drive.
// Assumes oe_n low means the router drives; undriven pins show the external pull.
`timescale 1ns/1ps
module pad_model (
   // Router pad side
   input wire logic [23:0] i_out,
   input wire logic [23:0] i_oe_n,
   // External level and resolved pin
   input wire logic [23:0] i_ext,
   output logic [23:0] o_pin
);
   assign o_pin = (i_out & ~i_oe_n) | (i_ext & i_oe_n);
endmodule // pad_model

// File: pin_router.sv
// Peripheral pin router: six routing registers steer peripheral signals
// onto port A, B and C pins and route pin levels back to peripherals.
// Assumes peripheral outputs and enables come from logic on i_clk_sys,
// pin levels arrive asynchronously, and the pad drives when oe_n is low.
`timescale 1ns/1ps

// Notes on behaviour
// - Event output B sits on PB2 when its bit is clear and on PB7 when set.
// - Event output A sits on PA2 when its bit is clear and on PA7 when set.
// - Logic cell 3 output moves from PC4 to PA5 when set; inputs stay PC0 to PC2.
// - Logic cell 2 output moves from PB3 to PB6 when set; inputs stay PB0 to PB2.
// - Logic cell 1 output moves from PA7 to PC1 when set; inputs stay PC3 to PC5.
// - Logic cell 0 output moves from PA4 to PB4 when set; inputs stay PA0 to PA2.
// - Serial port 1 uses PA1, PA2, PA3, PA4 at zero and PC2, PC1, PC0, PC3 at one.
// - Serial port 0 uses PB2, PB3, PB1, PB0 at zero and PA1, PA2, PA3, PA4 at one.
// - The SPI port uses PA1, PA2, PA3, PA4 at zero and PC2, PC1, PC0, PC3 at one.
// - A two-bit field of 3 disconnects its peripheral; software never writes 2.
// - Every routing register resets to zero, selecting the default pins.
// - The timer A register holds six one-bit waveform output selects in bits 5:0.
// - The timer B register uses bit 1 for its second output and bit 0 for its first.
module pin_router (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // Register port
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rd_data,
   // Peripheral outputs and their drive enables
   input wire logic [1:0] i_event_out,
   input wire logic [1:0] i_event_out_en,
   input wire logic [3:0] i_logic_cell_out,
   input wire logic [3:0] i_logic_cell_out_en,
   input wire logic [1:0] i_serial_tx,
   input wire logic [1:0] i_serial_clock,
   input wire logic [1:0] i_serial_direction,
   input wire logic [1:0] i_serial_en,
   input wire logic i_spi_mosi,
   input wire logic i_spi_sck,
   input wire logic i_spi_ss,
   input wire logic i_spi_en,
   input wire logic [5:0] i_timer_a_wo,
   input wire logic [5:0] i_timer_a_en,
   input wire logic [1:0] i_timer_b_wo,
   input wire logic [1:0] i_timer_b_en,
   // Peripheral inputs
   output logic [2:0] o_logic_cell0_in,
   output logic [2:0] o_logic_cell1_in,
   output logic [2:0] o_logic_cell2_in,
   output logic [2:0] o_logic_cell3_in,
   output logic o_serial_port0_rx,
   output logic o_serial_port1_rx,
   output logic o_spi_miso,
   // Pins
   input wire logic [7:0] i_pa_in,
   input wire logic [7:0] i_pb_in,
   input wire logic [7:0] i_pc_in,
   output logic [7:0] o_pa_out,
   output logic [7:0] o_pb_out,
   output logic [7:0] o_pc_out,
   output logic [7:0] o_pa_oe_n,
   output logic [7:0] o_pb_oe_n,
   output logic [7:0] o_pc_oe_n
);

   ////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [7:0] event_out_route;
      logic [7:0] logic_cell_route;
      logic [7:0] serial_port_route;
      logic [7:0] spi_route;
      logic [7:0] timer_a_route;
      logic [7:0] timer_b_route;
      logic [7:0] rd_data;
      logic [2:0][7:0] pin_sync1;
      logic [2:0][7:0] pin_sync2;
      logic [2:0][7:0] pin_out;
      logic [2:0][7:0] pin_oe_n;
      logic [2:0] logic_cell0_in;
      logic [2:0] logic_cell1_in;
      logic [2:0] logic_cell2_in;
      logic [2:0] logic_cell3_in;
      logic serial_port0_rx;
      logic serial_port1_rx;
      logic spi_miso;
   } state_t;

   localparam state_t STATE_RESET = '{
      event_out_route: pin_router_pkg::ROUTE_RESET,
      logic_cell_route: pin_router_pkg::ROUTE_RESET,
      serial_port_route: pin_router_pkg::ROUTE_RESET,
      spi_route: pin_router_pkg::ROUTE_RESET,
      timer_a_route: pin_router_pkg::ROUTE_RESET,
      timer_b_route: pin_router_pkg::ROUTE_RESET,
      rd_data: 8'h00,
      pin_sync1: '0,
      pin_sync2: '0,
      pin_out: '0,
      pin_oe_n: {3{pin_router_pkg::PIN_OE_N_RESET}},
      logic_cell0_in: 3'h0,
      logic_cell1_in: 3'h0,
      logic_cell2_in: 3'h0,
      logic_cell3_in: 3'h0,
      serial_port0_rx: pin_router_pkg::RX_IDLE,
      serial_port1_rx: pin_router_pkg::RX_IDLE,
      spi_miso: 1'b0
   };

   state_t state;
   state_t next_state;
   logic [2:0][7:0] pd;
   logic [2:0][7:0] pe;
   logic [1:0] ser0_sel;
   logic [1:0] ser1_sel;
   logic [1:0] spi_sel;
   logic [7:0] pa;
   logic [7:0] pb;
   logic [7:0] pc;

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_state = state;
      pd = '0;
      pe = '0;
      pa = state.pin_sync2[pin_router_pkg::PORT_A];
      pb = state.pin_sync2[pin_router_pkg::PORT_B];
      pc = state.pin_sync2[pin_router_pkg::PORT_C];
      ser0_sel = state.serial_port_route[pin_router_pkg::SERIAL_PORT0_LSB +: 2];
      ser1_sel = state.serial_port_route[pin_router_pkg::SERIAL_PORT1_LSB +: 2];
      spi_sel = state.spi_route[pin_router_pkg::SPI_PORT_LSB +: 2];

      // Register writes; unmapped bits are masked off
      if (i_wr) begin
         case (i_addr)
            pin_router_pkg::OFF_EVENT_OUT_ROUTE: begin
               next_state.event_out_route = i_wr_data & pin_router_pkg::MASK_EVENT_OUT_ROUTE;
            end
            pin_router_pkg::OFF_LOGIC_CELL_ROUTE: begin
               next_state.logic_cell_route = i_wr_data & pin_router_pkg::MASK_LOGIC_CELL_ROUTE;
            end
            pin_router_pkg::OFF_SERIAL_PORT_ROUTE: begin
               next_state.serial_port_route = i_wr_data & pin_router_pkg::MASK_SERIAL_PORT_ROUTE;
            end
            pin_router_pkg::OFF_SPI_ROUTE: begin
               next_state.spi_route = i_wr_data & pin_router_pkg::MASK_SPI_ROUTE;
            end
            pin_router_pkg::OFF_TIMER_A_ROUTE: begin
               next_state.timer_a_route = i_wr_data & pin_router_pkg::MASK_TIMER_A_ROUTE;
            end
            pin_router_pkg::OFF_TIMER_B_ROUTE: begin
               next_state.timer_b_route = i_wr_data & pin_router_pkg::MASK_TIMER_B_ROUTE;
            end
            default: begin
            end
         endcase
      end

      // Read data stands for one cycle only; unmapped reads return zero
      next_state.rd_data = 8'h00;
      if (i_rd) begin
         case (i_addr)
            pin_router_pkg::OFF_EVENT_OUT_ROUTE: next_state.rd_data = state.event_out_route;
            pin_router_pkg::OFF_LOGIC_CELL_ROUTE: next_state.rd_data = state.logic_cell_route;
            pin_router_pkg::OFF_SERIAL_PORT_ROUTE: next_state.rd_data = state.serial_port_route;
            pin_router_pkg::OFF_SPI_ROUTE: next_state.rd_data = state.spi_route;
            pin_router_pkg::OFF_TIMER_A_ROUTE: next_state.rd_data = state.timer_a_route;
            pin_router_pkg::OFF_TIMER_B_ROUTE: next_state.rd_data = state.timer_b_route;
            default: next_state.rd_data = 8'h00;
         endcase
      end

      // Pin synchronisers; only the second stage is read
      next_state.pin_sync1[pin_router_pkg::PORT_A] = i_pa_in;
      next_state.pin_sync1[pin_router_pkg::PORT_B] = i_pb_in;
      next_state.pin_sync1[pin_router_pkg::PORT_C] = i_pc_in;
      next_state.pin_sync2 = state.pin_sync1;

      // Output drives. Later entries win where two groups claim one pin,
      // so software must keep groups apart; timers sit lowest.
      for (int i = 0; i < 6; i++) begin
         if (i_timer_a_en[i]) begin
            if (i < 3) begin
               if (state.timer_a_route[i]) begin
                  pd[pin_router_pkg::PORT_B][i + 3] = i_timer_a_wo[i];
                  pe[pin_router_pkg::PORT_B][i + 3] = 1'b1;
               end else begin
                  pd[pin_router_pkg::PORT_B][i] = i_timer_a_wo[i];
                  pe[pin_router_pkg::PORT_B][i] = 1'b1;
               end
            end else begin
               if (state.timer_a_route[i]) begin
                  pd[pin_router_pkg::PORT_C][i] = i_timer_a_wo[i];
                  pe[pin_router_pkg::PORT_C][i] = 1'b1;
               end else begin
                  pd[pin_router_pkg::PORT_A][i] = i_timer_a_wo[i];
                  pe[pin_router_pkg::PORT_A][i] = 1'b1;
               end
            end
         end
      end
      if (i_timer_b_en[0]) begin
         if (state.timer_b_route[pin_router_pkg::TIMER_B_FIRST_BIT]) begin
            pd[pin_router_pkg::PORT_C][0] = i_timer_b_wo[0];
            pe[pin_router_pkg::PORT_C][0] = 1'b1;
         end else begin
            pd[pin_router_pkg::PORT_A][5] = i_timer_b_wo[0];
            pe[pin_router_pkg::PORT_A][5] = 1'b1;
         end
      end
      if (i_timer_b_en[1]) begin
         if (state.timer_b_route[pin_router_pkg::TIMER_B_SECOND_BIT]) begin
            pd[pin_router_pkg::PORT_C][4] = i_timer_b_wo[1];
            pe[pin_router_pkg::PORT_C][4] = 1'b1;
         end else begin
            pd[pin_router_pkg::PORT_A][3] = i_timer_b_wo[1];
            pe[pin_router_pkg::PORT_A][3] = 1'b1;
         end
      end

      // SPI host: MOSI, SCK, SS out; reserved and none both disconnect
      if (i_spi_en && spi_sel == pin_router_pkg::SEL_DEFAULT) begin
         pd[pin_router_pkg::PORT_A][3:1] = {i_spi_sck, 1'b0, i_spi_mosi};
         pe[pin_router_pkg::PORT_A][3:1] = 3'h5;
         pd[pin_router_pkg::PORT_A][4] = i_spi_ss;
         pe[pin_router_pkg::PORT_A][4] = 1'b1;
      end else if (i_spi_en && spi_sel == pin_router_pkg::SEL_ALTERNATE) begin
         pd[pin_router_pkg::PORT_C][3:2] = {i_spi_ss, i_spi_mosi};
         pe[pin_router_pkg::PORT_C][3:2] = 2'h3;
         pd[pin_router_pkg::PORT_C][0] = i_spi_sck;
         pe[pin_router_pkg::PORT_C][0] = 1'b1;
      end

      // Serial port 1: TX, clock, direction out
      if (i_serial_en[1] && ser1_sel == pin_router_pkg::SEL_DEFAULT) begin
         pd[pin_router_pkg::PORT_A][4:1] = {i_serial_direction[1], i_serial_clock[1], 1'b0,
                                            i_serial_tx[1]};
         pe[pin_router_pkg::PORT_A][4:1] = 4'hD;
      end else if (i_serial_en[1] && ser1_sel == pin_router_pkg::SEL_ALTERNATE) begin
         pd[pin_router_pkg::PORT_C][3:2] = {i_serial_direction[1], i_serial_tx[1]};
         pe[pin_router_pkg::PORT_C][3:2] = 2'h3;
         pd[pin_router_pkg::PORT_C][0] = i_serial_clock[1];
         pe[pin_router_pkg::PORT_C][0] = 1'b1;
      end

      // Serial port 0
      if (i_serial_en[0] && ser0_sel == pin_router_pkg::SEL_DEFAULT) begin
         pd[pin_router_pkg::PORT_B][2:0] = {i_serial_tx[0], i_serial_clock[0],
                                            i_serial_direction[0]};
         pe[pin_router_pkg::PORT_B][2:0] = 3'h7;
      end else if (i_serial_en[0] && ser0_sel == pin_router_pkg::SEL_ALTERNATE) begin
         pd[pin_router_pkg::PORT_A][4:1] = {i_serial_direction[0], i_serial_clock[0], 1'b0,
                                            i_serial_tx[0]};
         pe[pin_router_pkg::PORT_A][4:1] = 4'hD;
      end

      // Logic cell outputs
      if (i_logic_cell_out_en[0]) begin
         if (state.logic_cell_route[0]) begin
            pd[pin_router_pkg::PORT_B][4] = i_logic_cell_out[0];
            pe[pin_router_pkg::PORT_B][4] = 1'b1;
         end else begin
            pd[pin_router_pkg::PORT_A][4] = i_logic_cell_out[0];
            pe[pin_router_pkg::PORT_A][4] = 1'b1;
         end
      end
      if (i_logic_cell_out_en[1]) begin
         if (state.logic_cell_route[1]) begin
            pd[pin_router_pkg::PORT_C][1] = i_logic_cell_out[1];
            pe[pin_router_pkg::PORT_C][1] = 1'b1;
         end else begin
            pd[pin_router_pkg::PORT_A][7] = i_logic_cell_out[1];
            pe[pin_router_pkg::PORT_A][7] = 1'b1;
         end
      end
      if (i_logic_cell_out_en[2]) begin
         if (state.logic_cell_route[2]) begin
            pd[pin_router_pkg::PORT_B][6] = i_logic_cell_out[2];
            pe[pin_router_pkg::PORT_B][6] = 1'b1;
         end else begin
            pd[pin_router_pkg::PORT_B][3] = i_logic_cell_out[2];
            pe[pin_router_pkg::PORT_B][3] = 1'b1;
         end
      end
      if (i_logic_cell_out_en[3]) begin
         if (state.logic_cell_route[3]) begin
            pd[pin_router_pkg::PORT_A][5] = i_logic_cell_out[3];
            pe[pin_router_pkg::PORT_A][5] = 1'b1;
         end else begin
            pd[pin_router_pkg::PORT_C][4] = i_logic_cell_out[3];
            pe[pin_router_pkg::PORT_C][4] = 1'b1;
         end
      end

      // Event outputs take top priority
      if (i_event_out_en[0]) begin
         if (state.event_out_route[pin_router_pkg::EVENT_OUTPUT_A_BIT]) begin
            pd[pin_router_pkg::PORT_A][7] = i_event_out[0];
            pe[pin_router_pkg::PORT_A][7] = 1'b1;
         end else begin
            pd[pin_router_pkg::PORT_A][2] = i_event_out[0];
            pe[pin_router_pkg::PORT_A][2] = 1'b1;
         end
      end
      if (i_event_out_en[1]) begin
         if (state.event_out_route[pin_router_pkg::EVENT_OUTPUT_B_BIT]) begin
            pd[pin_router_pkg::PORT_B][7] = i_event_out[1];
            pe[pin_router_pkg::PORT_B][7] = 1'b1;
         end else begin
            pd[pin_router_pkg::PORT_B][2] = i_event_out[1];
            pe[pin_router_pkg::PORT_B][2] = 1'b1;
         end
      end

      // Registered pad drive: route and data change together, no glitch
      next_state.pin_out = pd;
      next_state.pin_oe_n = ~pe;

      // Pin levels back to peripherals; logic cell inputs never move
      next_state.logic_cell0_in = pa[2:0];
      next_state.logic_cell1_in = pc[5:3];
      next_state.logic_cell2_in = pb[2:0];
      next_state.logic_cell3_in = pc[2:0];
      case (ser0_sel)
         pin_router_pkg::SEL_DEFAULT: next_state.serial_port0_rx = pb[3];
         pin_router_pkg::SEL_ALTERNATE: next_state.serial_port0_rx = pa[2];
         default: next_state.serial_port0_rx = pin_router_pkg::RX_IDLE;
      endcase
      case (ser1_sel)
         pin_router_pkg::SEL_DEFAULT: next_state.serial_port1_rx = pa[2];
         pin_router_pkg::SEL_ALTERNATE: next_state.serial_port1_rx = pc[1];
         default: next_state.serial_port1_rx = pin_router_pkg::RX_IDLE;
      endcase
      case (spi_sel)
         pin_router_pkg::SEL_DEFAULT: next_state.spi_miso = pa[2];
         pin_router_pkg::SEL_ALTERNATE: next_state.spi_miso = pc[1];
         default: next_state.spi_miso = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         state <= STATE_RESET;
      end else begin
         state <= next_state;
      end
   end

   assign o_rd_data = state.rd_data;
   assign o_logic_cell0_in = state.logic_cell0_in;
   assign o_logic_cell1_in = state.logic_cell1_in;
   assign o_logic_cell2_in = state.logic_cell2_in;
   assign o_logic_cell3_in = state.logic_cell3_in;
   assign o_serial_port0_rx = state.serial_port0_rx;
   assign o_serial_port1_rx = state.serial_port1_rx;
   assign o_spi_miso = state.spi_miso;
   assign o_pa_out = state.pin_out[pin_router_pkg::PORT_A];
   assign o_pb_out = state.pin_out[pin_router_pkg::PORT_B];
   assign o_pc_out = state.pin_out[pin_router_pkg::PORT_C];
   assign o_pa_oe_n = state.pin_oe_n[pin_router_pkg::PORT_A];
   assign o_pb_oe_n = state.pin_oe_n[pin_router_pkg::PORT_B];
   assign o_pc_oe_n = state.pin_oe_n[pin_router_pkg::PORT_C];

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   a_event_b_pin: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      i_event_out_en[1] |=> ($past(state.event_out_route[1]) ?
         (!o_pb_oe_n[7] && o_pb_out[7] == $past(i_event_out[1])) :
         (!o_pb_oe_n[2] && o_pb_out[2] == $past(i_event_out[1]))))
      else $error("event output B not on its routed pin");
   a_event_a_pin: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      i_event_out_en[0] |=> ($past(state.event_out_route[0]) ?
         (!o_pa_oe_n[7] && o_pa_out[7] == $past(i_event_out[0])) :
         (!o_pa_oe_n[2] && o_pa_out[2] == $past(i_event_out[0]))))
      else $error("event output A not on its routed pin");
   a_cell3_inputs: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      $rose(i_pc_in[0]) |-> ##3 o_logic_cell3_in[0])
      else $error("logic cell 3 input not taken from PC0");
   a_cell2_out: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      (i_logic_cell_out_en[2] && state.logic_cell_route[2] && !i_event_out_en[1])
      |=> !o_pb_oe_n[6])
      else $error("logic cell 2 output not moved to PB6");
   a_serial1_alt: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      (i_serial_en[1] && state.serial_port_route[3:2] == 2'h1 && !i_spi_en)
      |=> (!o_pc_oe_n[2] && o_pc_out[2] == $past(i_serial_tx[1])))
      else $error("serial port 1 transmit not on PC2");
   a_serial0_none: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      (state.serial_port_route[1:0] == 2'h3) |=> o_serial_port0_rx)
      else $error("disconnected serial port 0 receive not idle");
   a_spi_default: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      (i_spi_en && state.spi_route[1:0] == 2'h0 && i_serial_en == 2'h0)
      |=> (!o_pa_oe_n[3] && o_pa_out[3] == $past(i_spi_sck) &&
         o_pa_oe_n[2] == !$past(i_event_out_en[0] && !state.event_out_route[0])))
      else $error("SPI clock not on PA3 or PA2 driven");
   a_reset_clear: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      !$past(i_resetn) |-> (state.event_out_route == 8'h00 && state.spi_route == 8'h00 &&
         state.serial_port_route == 8'h00 && o_pa_oe_n == 8'hFF))
      else $error("routing state not cleared by reset");
   a_timer_a_mask: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      (i_wr && i_addr == 3'h4) |=> state.timer_a_route == {2'h0, $past(i_wr_data[5:0])})
      else $error("timer A register write wrong");
   a_timer_b_alt: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      (i_timer_b_en == 2'h1 && state.timer_b_route[0] && i_serial_en == 2'h0 && !i_spi_en)
      |=> (!o_pc_oe_n[0] && o_pc_out[0] == $past(i_timer_b_wo[0]) &&
         o_pa_oe_n[5] == !$past((i_timer_a_en[5] && !state.timer_a_route[5]) ||
         (i_logic_cell_out_en[3] && state.logic_cell_route[3]))))
      else $error("timer B first output not on PC0");
   a_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      (i_rd && i_addr == 3'h3) |=> (o_rd_data[7:2] == 6'h00) ##1
      (o_rd_data == 8'h00 || $past(i_rd)))
      else $error("reserved bits of SPI register read nonzero");
   a_write_latency: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      (i_wr && i_addr == 3'h0 && i_event_out_en[0]) |=>
      (state.event_out_route[0] == $past(i_wr_data[0])) ##1
      (!$past(i_event_out_en[0]) || (o_pa_oe_n[2] == $past(state.event_out_route[0]))))
      else $error("event output A route not applied after write");

endmodule // pin_router

// File: pin_router_pkg.sv
// Constants for the peripheral pin router: register offsets, field
// positions, write masks, reset values and port indices.
// Assumes a byte-wide register port with a 3-bit address.
package pin_router_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [2:0] OFF_EVENT_OUT_ROUTE = 3'h0;
   localparam logic [2:0] OFF_LOGIC_CELL_ROUTE = 3'h1;
   localparam logic [2:0] OFF_SERIAL_PORT_ROUTE = 3'h2;
   localparam logic [2:0] OFF_SPI_ROUTE = 3'h3;
   localparam logic [2:0] OFF_TIMER_A_ROUTE = 3'h4;
   localparam logic [2:0] OFF_TIMER_B_ROUTE = 3'h5;

   ////////////////////////////////////////////////////////////////////////
   // Writable bits of each register; the rest read as zero
   localparam logic [7:0] MASK_EVENT_OUT_ROUTE = 8'h03;
   localparam logic [7:0] MASK_LOGIC_CELL_ROUTE = 8'h0F;
   localparam logic [7:0] MASK_SERIAL_PORT_ROUTE = 8'h0F;
   localparam logic [7:0] MASK_SPI_ROUTE = 8'h03;
   localparam logic [7:0] MASK_TIMER_A_ROUTE = 8'h3F;
   localparam logic [7:0] MASK_TIMER_B_ROUTE = 8'h03;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] ROUTE_RESET = 8'h00;
   localparam logic [7:0] PIN_OE_N_RESET = 8'hFF;
   localparam logic RX_IDLE = 1'b1;

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int EVENT_OUTPUT_A_BIT = 0;
   localparam int EVENT_OUTPUT_B_BIT = 1;
   localparam int SERIAL_PORT0_LSB = 0;
   localparam int SERIAL_PORT1_LSB = 2;
   localparam int SPI_PORT_LSB = 0;
   localparam int TIMER_B_FIRST_BIT = 0;
   localparam int TIMER_B_SECOND_BIT = 1;

   ////////////////////////////////////////////////////////////////////////
   // Two-bit field encodings
   localparam logic [1:0] SEL_DEFAULT = 2'h0;
   localparam logic [1:0] SEL_ALTERNATE = 2'h1;
   localparam logic [1:0] SEL_RESERVED = 2'h2;
   localparam logic [1:0] SEL_NONE = 2'h3;

   ////////////////////////////////////////////////////////////////////////
   // Port indices
   localparam int PORT_A = 0;
   localparam int PORT_B = 1;
   localparam int PORT_C = 2;

endpackage

// File: tb_top.sv
// Testbench for the pin router: register port, routing table and pin paths.
// Assumes the pad model closes the pin loop and a 100 MHz system clock.
`timescale 1ns/1ps
module tb_top;
   logic i_clk_sys = 1'b0;
   logic i_resetn = 1'b0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [2:0] i_addr = 3'h0;
   logic [7:0] i_wr_data = 8'h00;
   logic [7:0] o_rd_data;
   logic [39:0] s = 40'h0;
   logic [23:0] ext = 24'hFFFFFF;
   wire logic [23:0] pin, outs, oe;
   logic [2:0] c0, c1, c2, c3;
   logic rx0, rx1, miso;
   int error_cnt = 0;
   int comparisons = 0;
   int cyc = 0;
   // Address, write data, read back, peripheral stimulus, expected port A/B/C oe_n
   logic [82:0] rows [17] = '{
      {3'h0, 8'h00, 8'h00, 40'h4, 24'hFBFFFF}, {3'h0, 8'h01, 8'h01, 40'h4, 24'h7FFFFF},
      {3'h0, 8'hFE, 8'h02, 40'h8, 24'hFF7FFF}, {3'h1, 8'h08, 8'h08, 40'h800, 24'hDFFFFF},
      {3'h1, 8'h04, 8'h04, 40'h400, 24'hFFBFFF}, {3'h1, 8'h02, 8'h02, 40'h200, 24'hFFFFFD},
      {3'h1, 8'hF1, 8'h01, 40'h100, 24'hFFEFFF}, {3'h2, 8'h04, 8'h04, 40'h80000, 24'hFFFFF2},
      {3'h2, 8'h0C, 8'h0C, 40'h80000, 24'hFFFFFF}, {3'h2, 8'h00, 8'h00, 40'h40000, 24'hFFF8FF},
      {3'h2, 8'h01, 8'h01, 40'h40000, 24'hE5FFFF}, {3'h3, 8'h00, 8'h00, 40'h800000, 24'hE5FFFF},
      {3'h3, 8'h01, 8'h01, 40'h800000, 24'hFFFFF2}, {3'h3, 8'h03, 8'h03, 40'h800000, 24'hFFFFFF},
      {3'h4, 8'hFF, 8'h3F, 40'hFC0000000, 24'hFFC7C7},
      {3'h5, 8'hFF, 8'h03, 40'hC000000000, 24'hFFFFEE}, {3'h6, 8'hFF, 8'h00, 40'h0, 24'hFFFFFF}};
   pin_router uut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_addr(i_addr),
      .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
      .i_event_out(s[1:0]), .i_event_out_en(s[3:2]), .i_logic_cell_out(s[7:4]),
      .i_logic_cell_out_en(s[11:8]), .i_serial_tx(s[13:12]), .i_serial_clock(s[15:14]),
      .i_serial_direction(s[17:16]), .i_serial_en(s[19:18]), .i_spi_mosi(s[20]),
      .i_spi_sck(s[21]), .i_spi_ss(s[22]), .i_spi_en(s[23]), .i_timer_a_wo(s[29:24]),
      .i_timer_a_en(s[35:30]), .i_timer_b_wo(s[37:36]), .i_timer_b_en(s[39:38]),
      .o_logic_cell0_in(c0), .o_logic_cell1_in(c1), .o_logic_cell2_in(c2),
      .o_logic_cell3_in(c3), .o_serial_port0_rx(rx0), .o_serial_port1_rx(rx1),
      .o_spi_miso(miso),
      .i_pa_in(pin[23:16]), .i_pb_in(pin[15:8]), .i_pc_in(pin[7:0]), .o_pa_out(outs[23:16]),
      .o_pb_out(outs[15:8]), .o_pc_out(outs[7:0]), .o_pa_oe_n(oe[23:16]),
      .o_pb_oe_n(oe[15:8]), .o_pc_oe_n(oe[7:0]));
   pad_model pads (.i_out(outs), .i_oe_n(oe), .i_ext(ext), .o_pin(pin));
   ////////////////////////////////////////////////////////////////////////
   task complete_run;
      if (error_cnt == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task chk(input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Strobes drop at the taking edge, so back-to-back calls leave one idle cycle
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_wr_data <= d;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask
   task rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1 d = o_rd_data;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc == 2000) begin
         error_cnt++;
         complete_run();
      end
   end
   initial begin
      logic [7:0] d;
      repeat (16) @(posedge i_clk_sys);
      i_resetn <= 1'b1;
      for (int a = 0; a < 6; a++) begin
         rd(a[2:0], d);
         chk({16'h0, d}, 24'h0);
      end
      chk(oe, 24'hFFFFFF);
      foreach (rows[i]) begin
         wr(rows[i][82:80], rows[i][79:72]);
         s <= rows[i][63:24];
         rd(rows[i][82:80], d);
         chk({16'h0, d}, {16'h0, rows[i][71:64]});
         chk(oe, rows[i][23:0]);
      end
      // Pins follow a route write one edge after the write is taken
      wr(3'h0, 8'h00);
      s <= 40'h5;
      repeat (2) @(posedge i_clk_sys);
      wr(3'h0, 8'h01);
      #1 chk({8'h0, outs[23:16], oe[23:16]}, 24'h0004FB);
      @(posedge i_clk_sys);
      #1 chk({8'h0, outs[23:16], oe[23:16]}, 24'h00807F);
      wr(3'h2, 8'h00);
      s <= 40'h0;
      ext <= 24'hFFF7FD;
      repeat (4) @(posedge i_clk_sys);
      #1 chk({19'h0, c3, rx0, miso}, 24'h000014);
      // Alternate receive paths, every cell input, timer B first output on PC0
      wr(3'h2, 8'h05);
      wr(3'h3, 8'h01);
      s <= 40'h5000000000;
      ext <= 24'h5ACBA6;
      repeat (4) @(posedge i_clk_sys);
      #1 chk({9'h0, c0, c1, c2, c3, rx0, rx1, miso}, 24'h0028FB);
      chk({8'h0, outs[7:0], oe[7:0]}, 24'h0001FE);
      // Reset in mid-run clears routes that were left set
      @(posedge i_clk_sys);
      i_resetn <= 1'b0;
      s <= 40'h0;
      @(posedge i_clk_sys);
      i_resetn <= 1'b1;
      rd(3'h4, d);
      chk({16'h0, d}, 24'h0);
      chk(oe, 24'hFFFFFF);
      complete_run();
   end
endmodule // tb_top
